// *** rtl/pll_synth_if_counter.sv ***
/*
 * digital synthesizer (prescaler, swallow and main dividers, reference divider,
 * three-state phase comparator, charge pump current control with lock detection)
 * and the if counter with sampling timer and search-stop output.
 * assumes vco_in, crystal_trim_in and if_in are synchronous to ref_clk with each high and
 * low phase lasting at least one clock; settings are held stable by the host logic.
 */
`timescale 1ns/1ns
module pll_synth_if_counter
    import pll_synth_if_pkg::*;
#(
    parameter int SAMPLE_BASE_CYCLES = SAMPLE_BASE_CYC
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // signal inputs
    input  wire logic        vco_in,
    input  wire logic        crystal_trim_in,
    input  wire logic        if_in,
    // synthesizer settings
    input  wire logic [15:0] synth_divider_word,
    input  wire logic        synth_divider_wr,
    input  wire logic [2:0]  ref_divider_select,
    input  wire logic [4:0]  crystal_trim,
    // charge pump settings
    input  wire logic [3:0]  pump_high_current,
    input  wire logic [1:0]  pump_low_current,
    input  wire logic        pump_range_high,
    input  wire logic        auto_lock_current_en,
    input  wire logic        sw_low_current,
    // if counter settings
    input  wire logic        if_count_enable,
    input  wire logic [2:0]  sample_time_select,
    input  wire logic [4:0]  centre_offset,
    input  wire logic [2:0]  window_width,
    // charge pump and loop outputs
    output logic             pump_up_q,
    output logic             pump_down_q,
    output logic [3:0]       pump_magnitude_q,
    output logic             pump_range_q,
    output logic             loop_high_current_out_q,
    output logic [4:0]       crystal_trim_q,
    // status outputs
    output logic             divided_vco_pulse_q,
    output logic             ref_pulse_q,
    output logic             pll_locked_q,
    output logic [7:0]       status_byte_q,
    output logic             search_stop_q
);

    function automatic logic [15:0] ref_ratio(input logic [2:0] sel);
        ref_ratio = REF_DIV_TABLE[sel];
    endfunction : ref_ratio

    function automatic logic [20:0] len_mask(input logic [2:0] sel);
        len_mask = (IFC_ONE << (IFC_MIN_LEN + int'(sel))) - IFC_ONE;
    endfunction : len_mask

    // ------------------------------------------------------------------
    // edge detection of the synchronous signal inputs
    logic vco_prev_q;
    logic crystal_trim_prev_q;
    logic if_prev_q;
    logic vco_rise;
    logic crystal_trim_rise;
    logic if_rise;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vco_prev_q  <= 1'b0;
            crystal_trim_prev_q <= 1'b0;
            if_prev_q   <= 1'b0;
        end else begin
            vco_prev_q  <= vco_in;
            crystal_trim_prev_q <= crystal_trim_in;
            if_prev_q   <= if_in;
        end
    end

    assign vco_rise  = vco_in & ~vco_prev_q;
    assign crystal_trim_rise = crystal_trim_in & ~crystal_trim_prev_q;
    assign if_rise   = if_in & ~if_prev_q;

    // ------------------------------------------------------------------
    // divider word, latched on each host write
    logic [15:0] div_word_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            div_word_q <= 16'h0000;
        end else if (synth_divider_wr) begin
            div_word_q <= synth_divider_word;
        end
    end

    // ------------------------------------------------------------------
    // dual-modulus prescaler with swallow and main dividers
    logic [5:0]          presc_cnt_q;
    logic [SWALLOW_W-1:0] swallow_q;
    logic [MAIN_W-1:0]   main_q;
    logic [5:0]          presc_mod;
    logic                presc_tick;

    assign presc_mod  = (swallow_q != '0) ? PRESC_MOD_HIGH : PRESC_MOD_LOW;
    assign presc_tick = vco_rise && (presc_cnt_q == presc_mod - 6'h01);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            presc_cnt_q <= 6'h00;
        end else if (presc_tick) begin
            presc_cnt_q <= 6'h00;
        end else if (vco_rise) begin
            presc_cnt_q <= presc_cnt_q + 6'h01;
        end
    end

    // 33*a + 32*(b+1-a) vco periods per output pulse
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            swallow_q           <= '0;
            main_q              <= '0;
            divided_vco_pulse_q <= 1'b0;
        end else begin
            divided_vco_pulse_q <= 1'b0;
            if (presc_tick) begin
                if (main_q == '0) begin
                    main_q              <= div_word_q[MAIN_LSB +: MAIN_W];
                    swallow_q           <= div_word_q[SWALLOW_LSB +: SWALLOW_W];
                    divided_vco_pulse_q <= 1'b1;
                end else begin
                    main_q <= main_q - 11'h001;
                    if (swallow_q != '0) begin
                        swallow_q <= swallow_q - 5'h01;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // reference divider on the crystal signal
    logic [15:0] ref_cnt_q;
    logic        ref_tick;

    assign ref_tick = crystal_trim_rise && (ref_cnt_q >= ref_ratio(ref_divider_select) - 16'h0001);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_cnt_q   <= 16'h0000;
            ref_pulse_q <= 1'b0;
        end else begin
            ref_pulse_q <= ref_tick;
            if (ref_tick) begin
                ref_cnt_q <= 16'h0000;
            end else if (crystal_trim_rise) begin
                ref_cnt_q <= ref_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            crystal_trim_q <= 5'h00;
        end else begin
            crystal_trim_q <= crystal_trim;
        end
    end

    // ------------------------------------------------------------------
    // three-state phase comparator
    logic pfd_reset;

    assign pfd_reset = pump_up_q & pump_down_q;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pump_up_q   <= 1'b0;
            pump_down_q <= 1'b0;
        end else if (pfd_reset) begin
            pump_up_q   <= 1'b0;
            pump_down_q <= 1'b0;
        end else begin
            pump_up_q   <= pump_up_q | ref_pulse_q;
            pump_down_q <= pump_down_q | divided_vco_pulse_q;
        end
    end

    // ------------------------------------------------------------------
    // lock detector: width of the last phase error pulse
    logic [7:0] pw_cnt_q;
    logic       phase_small;

    assign phase_small = pw_cnt_q < LOCK_WIN_CYC;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pw_cnt_q     <= 8'h00;
            pll_locked_q <= 1'b0;
        end else if (pfd_reset) begin
            pw_cnt_q     <= 8'h00;
            pll_locked_q <= phase_small;
        end else if ((pump_up_q ^ pump_down_q) && (pw_cnt_q != 8'hff)) begin
            pw_cnt_q <= pw_cnt_q + 8'h01;
        end
    end

    // ------------------------------------------------------------------
    // charge pump current mode
    logic auto_low_q;
    logic high_mode;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            auto_low_q <= 1'b0;
        end else if (synth_divider_wr || !auto_lock_current_en) begin
            auto_low_q <= 1'b0;
        end else if (pfd_reset && phase_small) begin
            auto_low_q <= 1'b1;
        end
    end

    assign high_mode = !(sw_low_current || auto_low_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pump_magnitude_q        <= 4'h0;
            pump_range_q            <= 1'b0;
            loop_high_current_out_q <= 1'b0;
        end else begin
            pump_magnitude_q        <= high_mode ? pump_high_current : {2'b00, pump_low_current};
            pump_range_q            <= high_mode & pump_range_high;
            loop_high_current_out_q <= high_mode;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_byte_q <= STATUS_RESET;
        end else begin
            status_byte_q                  <= STATUS_RESET;
            status_byte_q[STATUS_LOCK_BIT] <= pll_locked_q;
        end
    end

    // ------------------------------------------------------------------
    // sampling timer and if main counter
    ifc_state_t  ifc_state_q;
    logic [15:0] base_cnt_q;
    logic [7:0]  tick_cnt_q;
    logic [2:0]  sel_q;
    logic [2:0]  ew_q;
    logic [20:0] mask_q;
    logic [20:0] ifc_q;
    logic        run_ok;
    logic        base_tick;
    logic        gate_end;
    logic [20:0] preset;
    logic [20:0] err_win;
    logic [20:0] over_cnt;
    logic [20:0] under_cnt;
    logic        count_pass;

    assign run_ok    = if_count_enable && pll_locked_q;
    assign base_tick = base_cnt_q == 16'(SAMPLE_BASE_CYCLES - 1);
    assign gate_end  = base_tick && (tick_cnt_q == (8'h01 << sel_q) - 8'h01);
    assign preset    = (((21'(centre_offset) + IFC_CENTRE_BASE + IFC_ONE) << sample_time_select) - IFC_ONE)
                       & len_mask(sample_time_select);
    assign err_win   = (21'(ew_q) + IFC_ONE) << sel_q;
    assign over_cnt  = (mask_q - ifc_q) & mask_q;
    assign under_cnt = (ifc_q + IFC_ONE) & mask_q;
    assign count_pass = (over_cnt <= err_win) || (under_cnt <= err_win);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ifc_state_q <= IFC_IDLE;
        end else begin
            case (ifc_state_q)
                IFC_IDLE: begin
                    if (run_ok) begin
                        ifc_state_q <= IFC_RUN;
                    end
                end
                IFC_RUN: begin
                    if (!run_ok) begin
                        ifc_state_q <= IFC_IDLE;
                    end else if (gate_end) begin
                        ifc_state_q <= IFC_EVAL;
                    end
                end
                IFC_EVAL: begin
                    ifc_state_q <= IFC_IDLE;
                end
                default: begin
                    ifc_state_q <= IFC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            base_cnt_q <= 16'h0000;
            tick_cnt_q <= 8'h00;
        end else if (ifc_state_q != IFC_RUN) begin
            base_cnt_q <= 16'h0000;
            tick_cnt_q <= 8'h00;
        end else if (base_tick) begin
            base_cnt_q <= 16'h0000;
            tick_cnt_q <= tick_cnt_q + 8'h01;
        end else begin
            base_cnt_q <= base_cnt_q + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sel_q  <= 3'h0;
            ew_q   <= 3'h0;
            mask_q <= 21'h0007ff;
            ifc_q  <= 21'h000000;
        end else if (ifc_state_q == IFC_IDLE) begin
            sel_q  <= sample_time_select;
            ew_q   <= window_width;
            mask_q <= len_mask(sample_time_select);
            ifc_q  <= preset;
        end else if ((ifc_state_q == IFC_RUN) && if_rise) begin
            ifc_q <= (ifc_q - IFC_ONE) & mask_q;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            search_stop_q <= 1'b0;
        end else if (!run_ok) begin
            search_stop_q <= 1'b0;
        end else if (ifc_state_q == IFC_EVAL) begin
            search_stop_q <= count_pass;
        end
    end

endmodule : pll_synth_if_counter

// *** rtl/pll_synth_if_pkg.sv ***
/*
 * constants, tables and types for the synthesizer divider chain, phase comparator,
 * lock detector, sampling timer and if counter.
 * assumes a single 125 mhz system clock; all timing counts derive from its period.
 */
package pll_synth_if_pkg;

    // synthesizer divider word layout
    localparam int              SWALLOW_LSB     = 0;
    localparam int              SWALLOW_W       = 5;
    localparam int              MAIN_LSB        = 5;
    localparam int              MAIN_W          = 11;
    localparam int              DIV_WORD_W      = 16;

    // dual-modulus prescaler terminal counts (divide by 32 or 33)
    localparam logic [5:0]      PRESC_MOD_LOW   = 6'h20;
    localparam logic [5:0]      PRESC_MOD_HIGH  = 6'h21;

    // clock and lock window timing
    localparam int              CLK_PERIOD_PS   = 8000;
    localparam int              LOCK_WIN_NS     = 40;
    localparam int              LOCK_WIN_CYC_I  = (LOCK_WIN_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [7:0]      LOCK_WIN_CYC    = 8'((LOCK_WIN_CYC_I < 1) ? 1 : LOCK_WIN_CYC_I);

    // sampling timer base period
    localparam int              SAMPLE_BASE_US  = 160;
    localparam int              SAMPLE_BASE_CYC = (SAMPLE_BASE_US * 1000 * 1000) / CLK_PERIOD_PS;

    // if main counter
    localparam int              IFC_W           = 21;
    localparam int              IFC_MIN_LEN     = 11;
    localparam logic [20:0]     IFC_CENTRE_BASE = 21'h0006a0;
    localparam logic [20:0]     IFC_ONE         = 21'h000001;

    // reference divider ratios chosen by ref_divider_select
    localparam logic [15:0]     REF_DIV_TABLE [8] = '{16'h0002, 16'h0004, 16'h0008, 16'h0010,
                                                      16'h0020, 16'h0040, 16'h0080, 16'h0100};

    // host status byte
    localparam int              STATUS_LOCK_BIT = 3;
    localparam logic [7:0]      STATUS_RESET    = 8'h00;

    typedef enum logic [2:0] {
        IFC_IDLE = 3'b001,
        IFC_RUN  = 3'b010,
        IFC_EVAL = 3'b100
    } ifc_state_t;

endpackage : pll_synth_if_pkg

// *** tb/pll_far_side.sv ***
/* far side model: vco steered directly by the pump pulses, crystal and limited if sources.
   assumes the pump outputs are registered on ref_clk. */
`timescale 1ns/1ns
module pll_far_side (
    // clock, reset and loop mode
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic loop_closed,
    // pump pulses
    input  wire logic pump_up_q,
    input  wire logic pump_down_q,
    // generated signals
    output logic      vco_in,
    output logic      crystal_trim_in,
    output logic      if_in
);
    logic [1:0] vco_cnt_q;
    logic [1:0] vco_lim;
    logic       crystal_trim_cnt_q;

    // up shortens and down stretches the vco half period
    assign vco_lim = !loop_closed ? 2'h0 : pump_up_q ? 2'h0 : pump_down_q ? 2'h2 : 2'h1;

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vco_cnt_q <= 2'h0;
            vco_in    <= 1'b0;
        end else if (vco_cnt_q >= vco_lim) begin
            vco_cnt_q <= 2'h0;
            vco_in    <= ~vco_in;
        end else begin
            vco_cnt_q <= vco_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            crystal_trim_cnt_q <= 1'b0;
            crystal_trim_in    <= 1'b0;
            if_in      <= 1'b0;
        end else begin
            crystal_trim_cnt_q <= ~crystal_trim_cnt_q;
            crystal_trim_in    <= crystal_trim_in ^ crystal_trim_cnt_q;
            if_in      <= ~if_in;
        end
    end
endmodule : pll_far_side

// *** tb/pll_synth_if_counter_checker.sv ***
/* port-level assertions for pll_synth_if_counter.
   assumes one clock domain and asynchronous active-high reset. */
`timescale 1ns/1ns
module pll_synth_if_counter_checker
    import pll_synth_if_pkg::*;
#(
    parameter int SAMPLE_BASE_CYCLES = SAMPLE_BASE_CYC
) (
    // clock, reset
    input wire logic       ref_clk,
    input wire logic       rst,
    // settings
    input wire logic       synth_divider_wr,
    input wire logic       sw_low_current,
    input wire logic [3:0] pump_high_current,
    input wire logic [1:0] pump_low_current,
    input wire logic       if_count_enable,
    // outputs
    input wire logic       pump_up_q,
    input wire logic       pump_down_q,
    input wire logic [3:0] pump_magnitude_q,
    input wire logic       pump_range_q,
    input wire logic       loop_high_current_out_q,
    input wire logic       divided_vco_pulse_q,
    input wire logic       ref_pulse_q,
    input wire logic       pll_locked_q,
    input wire logic [7:0] status_byte_q,
    input wire logic       search_stop_q
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_write;
        synth_divider_wr && !sw_low_current ##1 !sw_low_current;
    endsequence
    sequence s_overlap;
        pump_up_q && pump_down_q && !ref_pulse_q && !divided_vco_pulse_q;
    endsequence

    a_pump_overlap_clear: assert property (s_overlap |=> !pump_up_q && !pump_down_q)
        else $error("pump pulses not cleared after overlap");
    a_up_after_ref: assert property (ref_pulse_q && !(pump_up_q && pump_down_q) |=> pump_up_q)
        else $error("no up pulse after reference");
    a_down_after_vco: assert property (divided_vco_pulse_q && !(pump_up_q && pump_down_q) |=> pump_down_q)
        else $error("no down pulse after divided vco");
    a_write_high_current: assert property (s_write |=> loop_high_current_out_q)
        else $error("write did not restore high current");
    a_range_in_high: assert property (pump_range_q |-> loop_high_current_out_q)
        else $error("range bit outside high current");
    a_mag_high_mode: assert property (loop_high_current_out_q && $stable(pump_high_current)
        |-> pump_magnitude_q == $past(pump_high_current))
        else $error("high magnitude wrong");
    a_mag_low_mode: assert property (!$past(rst) && !loop_high_current_out_q
        |-> pump_magnitude_q == {2'h0, $past(pump_low_current)})
        else $error("low magnitude wrong");
    a_status_lock_bit: assert property (status_byte_q == {4'h0, $past(pll_locked_q), 3'h0})
        else $error("status lock bit wrong");
    a_search_gate_low: assert property ((!if_count_enable || !pll_locked_q) |=> !search_stop_q)
        else $error("search stop high while idle");
endmodule : pll_synth_if_counter_checker

bind pll_synth_if_counter pll_synth_if_counter_checker #(.SAMPLE_BASE_CYCLES(SAMPLE_BASE_CYCLES))
    pll_synth_if_counter_checker_inst (.ref_clk(ref_clk), .rst(rst), .synth_divider_wr(synth_divider_wr),
    .sw_low_current(sw_low_current), .pump_high_current(pump_high_current),
    .pump_low_current(pump_low_current), .if_count_enable(if_count_enable), .pump_up_q(pump_up_q),
    .pump_down_q(pump_down_q), .pump_magnitude_q(pump_magnitude_q), .pump_range_q(pump_range_q),
    .loop_high_current_out_q(loop_high_current_out_q), .divided_vco_pulse_q(divided_vco_pulse_q),
    .ref_pulse_q(ref_pulse_q), .pll_locked_q(pll_locked_q), .status_byte_q(status_byte_q),
    .search_stop_q(search_stop_q));

// *** tb/pll_synth_if_counter_tb.sv ***
/* self-checking bench for pll_synth_if_counter.
   assumes the package, checker and far-side model are compiled first. */
`timescale 1ns/1ns
module pll_synth_if_counter_tb;
    import pll_synth_if_pkg::*;

    localparam int BASE = 3394;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        loop_closed = 1'b0;
    logic        vco_in, crystal_trim_in, if_in, synth_divider_wr = 1'b0, sw_low_current = 1'b0;
    logic [15:0] synth_divider_word = 16'h0000;
    logic [2:0]  ref_divider_select = 3'h0, sample_time_select = 3'h0, window_width = 3'h0;
    logic [4:0]  crystal_trim = 5'h00, centre_offset = 5'h00, crystal_trim_q;
    logic [3:0]  pump_high_current = 4'h0, pump_magnitude_q;
    logic [1:0]  pump_low_current = 2'h0;
    logic        pump_range_high = 1'b0, auto_lock_current_en = 1'b0, if_count_enable = 1'b0;
    logic        pump_up_q, pump_down_q, pump_range_q, loop_high_current_out_q;
    logic        divided_vco_pulse_q, ref_pulse_q, pll_locked_q, search_stop_q;
    logic [7:0]  status_byte_q;
    int          err_total = 0;
    int          n_compared = 0;

    always #4 ref_clk = ~ref_clk;

    pll_synth_if_counter #(.SAMPLE_BASE_CYCLES(BASE)) pll_synth_if_counter_inst (.ref_clk(ref_clk), .rst(rst),
        .vco_in(vco_in), .crystal_trim_in(crystal_trim_in), .if_in(if_in), .synth_divider_word(synth_divider_word),
        .synth_divider_wr(synth_divider_wr), .ref_divider_select(ref_divider_select),
        .crystal_trim(crystal_trim), .pump_high_current(pump_high_current), .pump_low_current(pump_low_current),
        .pump_range_high(pump_range_high), .auto_lock_current_en(auto_lock_current_en),
        .sw_low_current(sw_low_current), .if_count_enable(if_count_enable),
        .sample_time_select(sample_time_select), .centre_offset(centre_offset), .window_width(window_width),
        .pump_up_q(pump_up_q), .pump_down_q(pump_down_q), .pump_magnitude_q(pump_magnitude_q),
        .pump_range_q(pump_range_q), .loop_high_current_out_q(loop_high_current_out_q),
        .crystal_trim_q(crystal_trim_q), .divided_vco_pulse_q(divided_vco_pulse_q), .ref_pulse_q(ref_pulse_q),
        .pll_locked_q(pll_locked_q), .status_byte_q(status_byte_q), .search_stop_q(search_stop_q));

    pll_far_side pll_far_side_inst (.ref_clk(ref_clk), .rst(rst), .loop_closed(loop_closed),
        .pump_up_q(pump_up_q), .pump_down_q(pump_down_q), .vco_in(vco_in), .crystal_trim_in(crystal_trim_in), .if_in(if_in));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : results

    task automatic write_word(input logic [15:0] w);
        @(negedge ref_clk);
        synth_divider_word = w;
        synth_divider_wr = 1'b1;
        @(negedge ref_clk);
        synth_divider_wr = 1'b0;
    endtask : write_word

    // cycles between the last two of three pulses
    task automatic gap(input bit use_ref, output int n);
        int c;
        c = 0;
        repeat (3) begin
            n = 0;
            do begin
                @(posedge ref_clk);
                #1;
                n++;
                c++;
            end while (!(use_ref ? ref_pulse_q : divided_vco_pulse_q) && c < 20000);
        end
    endtask : gap

    function automatic logic [3:0] exp_mag(input logic hi);
        return hi ? pump_high_current : {2'h0, pump_low_current};
    endfunction : exp_mag

    // edges per gate are BASE/2 << sel, so the shift cancels
    function automatic logic exp_pass(input int cf, input int ew);
        int d;
        d = cf + 1697 - BASE / 2;
        return ((d < 0) ? -d : d) <= ew + 1;
    endfunction : exp_pass

    initial begin
        int n, m, s, k;
        void'($urandom(32'h112d));
        pump_high_current = 4'($urandom);
        pump_low_current = 2'($urandom);
        pump_range_high = 1'b1;
        crystal_trim = 5'($urandom);
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) rst = 1'b0;
        for (k = 0; k < 4; k++) begin
            s = (k == 0) ? 0 : (k == 1) ? 31 : $urandom_range(31);
            m = s + ((k == 0) ? 0 : $urandom_range(8));
            write_word(16'((m << 5) | s));
            gap(1'b0, n);
            check("vco period", 32'(n), 32'(2 * (32 * m + s + 32)));
        end
        $display("test divider done");
        for (k = 0; k < 8; k++) begin
            @(negedge ref_clk) ref_divider_select = 3'(k);
            gap(1'b1, n);
            check("ref period", 32'(n), 32'(8 << k));
        end
        $display("test reference done");
        check("trim copy", crystal_trim_q, 32'(crystal_trim));
        @(negedge ref_clk);
        loop_closed = 1'b1;
        ref_divider_select = 3'h5;
        auto_lock_current_en = 1'b1;
        write_word(16'h0020);
        for (k = 0; k < 30000 && pll_locked_q !== 1'b1; k++) @(posedge ref_clk);
        repeat (3) @(posedge ref_clk);
        #1;
        check("locked", pll_locked_q, 1'b1);
        check("status", status_byte_q, 8'h08);
        check("auto low", loop_high_current_out_q, 1'b0);
        check("low mag", pump_magnitude_q, exp_mag(1'b0));
        write_word(16'h0020);
        @(posedge ref_clk);
        #1;
        check("write high", loop_high_current_out_q, 1'b1);
        check("high mag", {pump_magnitude_q, pump_range_q}, {exp_mag(1'b1), 1'b1});
        @(negedge ref_clk) auto_lock_current_en = 1'b0;
        repeat (600) @(posedge ref_clk);
        #1;
        check("stay high", loop_high_current_out_q, 1'b1);
        @(negedge ref_clk) sw_low_current = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        check("sw low", {loop_high_current_out_q, pump_range_q}, 2'h0);
        @(negedge ref_clk) sw_low_current = 1'b0;
        $display("test current done");
        @(negedge ref_clk);
        if_count_enable = 1'b1;
        window_width = 3'($urandom_range(5));
        for (k = 0; k < 3; k++) begin
            @(negedge ref_clk);
            sample_time_select = (k == 0) ? 3'h0 : 3'h1;
            centre_offset = 5'(window_width + ((k == 1) ? 2 : 0));
            repeat (4 * BASE + 20) @(posedge ref_clk);
            #1;
            check("search stop", search_stop_q, exp_pass(centre_offset, window_width));
        end
        @(negedge ref_clk) if_count_enable = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("stop off", search_stop_q, 1'b0);
        $display("test if counter done");
        results();
    end

    initial begin
        repeat (99000) @(posedge ref_clk);
        err_total++;
        results();
    end
endmodule : pll_synth_if_counter_tb
